// >>> rtl/sci_ide_port_ctl.sv
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// - Offsets 0-7 and 14 reach card registers
// - Control port 32 bits, four words
// - Reading card control clears detect interrupt
// - Bit 0 reads card presence, read-only
// - Bit 1 drives card power output
// - Bit 2 holds card in reset
// - Bit 3 enables insert/remove interrupt
// - Enable bit gates relayed card interrupt
// - Two separate active-high interrupt outputs
// - Card cycles use mode 0 strobe timing
module sci_ide_port_ctl (
    // Clock and reset
    input wire logic clk_in,
    input wire logic resetn_in,
    // Task-file slave port
    input wire logic [sci_pkg::IDE_ADDR_W-1:0] ide_address_in,
    input wire logic ide_read_in,
    input wire logic ide_write_in,
    input wire logic [sci_pkg::IDE_DATA_W-1:0] ide_writedata_in,
    output logic [sci_pkg::IDE_DATA_W-1:0] ide_readdata_out,
    output logic ide_waitrequest_out,
    // Control slave port, read latency one
    input wire logic [sci_pkg::CTL_ADDR_W-1:0] ctl_address_in,
    input wire logic ctl_read_in,
    input wire logic ctl_write_in,
    input wire logic [sci_pkg::CTL_DATA_W-1:0] ctl_writedata_in,
    output logic [sci_pkg::CTL_DATA_W-1:0] ctl_readdata_out,
    // Card pins
    output sci_pkg::sci_pin_type card_pins_out,
    output logic [sci_pkg::IDE_DATA_W-1:0] card_data_out,
    output logic card_data_oe_out,
    input wire logic [sci_pkg::IDE_DATA_W-1:0] card_data_in,
    input wire logic card_detect_in,
    input wire logic card_intrq_in,
    input wire logic card_iordy_in,
    // Interrupt requests
    output logic detect_irq_out,
    output logic card_irq_out
);
    import sci_pkg::*;

    sci_state_type st_q; // Registered state
    sci_state_type st_d; // Next state
    logic [2:0] pin_sync; // Detect, interrupt, ready after sync
    logic [IDE_DATA_W-1:0] data_sync; // Card data after sync
    logic tmr_load; // Start a phase
    logic [TMR_W-1:0] tmr_value; // Phase length minus one
    logic tmr_expired; // Phase time elapsed
    logic ide_req; // Task-file request present
    logic present_change; // Card presence moved
    logic ctl_rd_ctrl; // Read of card control word

    // Slow card pins into the clock domain
    sci_sync2 #(.W(3)) u_pin_sync (
        .clk_in(clk_in),
        .resetn_in(resetn_in),
        .async_in({card_iordy_in, card_intrq_in, card_detect_in}),
        .sync_out(pin_sync)
    );

    // Card data bus into the clock domain
    sci_sync2 #(.W(IDE_DATA_W)) u_data_sync (
        .clk_in(clk_in),
        .resetn_in(resetn_in),
        .async_in(card_data_in),
        .sync_out(data_sync)
    );

    // Times each phase of a card cycle
    sci_phase_timer #(.W(TMR_W)) u_timer (
        .clk_in(clk_in),
        .resetn_in(resetn_in),
        .load_in(tmr_load),
        .value_in(tmr_value),
        .expired_out(tmr_expired)
    );

    // Request and event decode
    assign ide_req = ide_read_in | ide_write_in;
    assign present_change = (pin_sync[0] != st_q.present);
    assign ctl_rd_ctrl = ctl_read_in && (ctl_address_in == CTL_CONTROL_IDX);

    // Next-state logic for card cycles, control words and interrupts
    always_comb
    begin
        st_d = st_q;
        tmr_load = 1'b0;
        tmr_value = SETUP_LOAD;

        // Card cycle sequencer
        case (st_q.state)
            PIO_IDLE:
            begin
                if (ide_req)
                begin
                    // Offset bit 3 picks the control block select
                    if (ide_address_in[IDE_CS1_BIT])
                        st_d.pins.cs_n = CS_BLOCK1;
                    else
                        st_d.pins.cs_n = CS_BLOCK0;
                    st_d.pins.addr = {8'h00, ide_address_in[2:0]};
                    st_d.is_write = ide_write_in;
                    st_d.data_out = ide_writedata_in;
                    st_d.data_oe = ide_write_in;
                    st_d.state = PIO_SETUP;
                    tmr_load = 1'b1;
                    tmr_value = SETUP_LOAD;
                end
            end
            PIO_SETUP:
            begin
                // Address setup done, open the strobe
                if (tmr_expired)
                begin
                    if (st_q.is_write)
                        st_d.pins.iowr_n = 1'b0;
                    else
                        st_d.pins.iord_n = 1'b0;
                    st_d.state = PIO_STROBE;
                    tmr_load = 1'b1;
                    tmr_value = STROBE_LOAD;
                end
            end
            PIO_STROBE:
            begin
                // Least width reached and card ready: close strobe
                if (tmr_expired && pin_sync[2])
                begin
                    st_d.pins.iord_n = 1'b1;
                    st_d.pins.iowr_n = 1'b1;
                    if (!st_q.is_write)
                        st_d.ide_rdata = data_sync;
                    st_d.state = PIO_HOLD;
                    tmr_load = 1'b1;
                    tmr_value = HOLD_LOAD;
                end
            end
            PIO_HOLD:
            begin
                // Hold address and data, then finish the bus transfer
                if (tmr_expired)
                begin
                    st_d.pins.cs_n = CS_NONE;
                    st_d.data_oe = 1'b0;
                    st_d.waitreq = 1'b0;
                    st_d.state = PIO_DONE;
                end
            end
            PIO_DONE:
            begin
                // One cycle of released wait, then recovery
                st_d.waitreq = 1'b1;
                st_d.state = PIO_RECOVER;
                tmr_load = 1'b1;
                tmr_value = RECOVER_LOAD;
            end
            PIO_RECOVER:
            begin
                // Keeps the full cycle time before the next access
                if (tmr_expired)
                    st_d.state = PIO_IDLE;
            end
            default:
            begin
                st_d.state = PIO_IDLE;
                st_d.pins.cs_n = CS_NONE;
                st_d.pins.iord_n = 1'b1;
                st_d.pins.iowr_n = 1'b1;
                st_d.data_oe = 1'b0;
                st_d.waitreq = 1'b1;
            end
        endcase

        // Card presence follows the synchronised pin
        st_d.present = pin_sync[0];

        // Control word writes; reserved words ignored
        if (ctl_write_in)
        begin
            if (ctl_address_in == CTL_CONTROL_IDX)
            begin
                st_d.power_on = ctl_writedata_in[POWER_BIT];
                st_d.reset_hold = ctl_writedata_in[RESET_BIT];
                st_d.det_irq_en = ctl_writedata_in[DET_IRQ_BIT];
            end
            else if (ctl_address_in == CTL_IRQ_IDX)
            begin
                st_d.card_irq_en = ctl_writedata_in[CARD_IRQ_BIT];
            end
        end

        // Control word reads; unused bits and words return zero
        st_d.ctl_rdata = 32'h00000000;
        if (ctl_read_in)
        begin
            if (ctl_address_in == CTL_CONTROL_IDX)
            begin
                st_d.ctl_rdata[PRESENT_BIT] = st_q.present;
                st_d.ctl_rdata[POWER_BIT] = st_q.power_on;
                st_d.ctl_rdata[RESET_BIT] = st_q.reset_hold;
                st_d.ctl_rdata[DET_IRQ_BIT] = st_q.det_irq_en;
            end
            else if (ctl_address_in == CTL_IRQ_IDX)
            begin
                st_d.ctl_rdata[CARD_IRQ_BIT] = st_q.card_irq_en;
            end
        end

        // Detect interrupt: cleared by read, a new change wins
        if (ctl_rd_ctrl)
            st_d.det_pending = 1'b0;
        if (present_change && st_q.det_irq_en)
            st_d.det_pending = 1'b1;

        // Two separate interrupt lines
        st_d.det_irq = st_d.det_pending & st_d.det_irq_en;
        st_d.card_irq = pin_sync[1] & st_q.card_irq_en;

        // Power and reset pins follow their bits
        st_d.pins.power = st_d.power_on;
        st_d.pins.reset_n = ~st_d.reset_hold;
    end

    // State register, loads STATE_RESET after reset
    always_ff @(posedge clk_in or negedge resetn_in)
    begin
        if (!resetn_in)
            st_q <= STATE_RESET;
        else
            st_q <= st_d;
    end

    // Outputs straight from the state register
    assign ide_readdata_out = st_q.ide_rdata;
    assign ide_waitrequest_out = st_q.waitreq;
    assign ctl_readdata_out = st_q.ctl_rdata;
    assign card_pins_out = st_q.pins;
    assign card_data_out = st_q.data_out;
    assign card_data_oe_out = st_q.data_oe;
    assign detect_irq_out = st_q.det_irq;
    assign card_irq_out = st_q.card_irq;

    // Checks on the sequencer and control words
    default clocking cb @(posedge clk_in);
    endclocking
    default disable iff (!resetn_in);

    a_addr_map: assert property (
        (st_q.state == PIO_IDLE && ide_req) |=>
        (card_pins_out.cs_n == ($past(ide_address_in[3]) ? CS_BLOCK1 : CS_BLOCK0))
        && (card_pins_out.addr[2:0] == $past(ide_address_in[2:0])))
        else $error("task-file offset mapped to wrong select or address");

    a_ctl_upper_zero: assert property (
        ctl_read_in |=> (ctl_readdata_out[31:4] == 28'h0000000))
        else $error("upper control bits not zero");

    a_reserved_zero: assert property (
        (ctl_read_in && ctl_address_in[1]) |=> (ctl_readdata_out == 32'h00000000))
        else $error("reserved control word not zero");

    a_read_clears: assert property (
        (ctl_rd_ctrl && !present_change) |=> !detect_irq_out)
        else $error("control read did not clear detect interrupt");

    a_power_pin: assert property (
        (ctl_write_in && ctl_address_in == CTL_CONTROL_IDX) |=>
        (card_pins_out.power == $past(ctl_writedata_in[1])))
        else $error("power pin does not follow written bit");

    a_reset_pin: assert property (
        (ctl_write_in && ctl_address_in == CTL_CONTROL_IDX) |=>
        (card_pins_out.reset_n == !$past(ctl_writedata_in[2])))
        else $error("card reset pin does not follow written bit");

    a_detect_irq: assert property (
        (present_change && st_q.det_irq_en && !(ctl_write_in
        && ctl_address_in == CTL_CONTROL_IDX)) |=> detect_irq_out)
        else $error("presence change raised no interrupt");

    a_card_irq_gate: assert property (
        (!st_q.card_irq_en) |=> !card_irq_out)
        else $error("card interrupt not suppressed");

    a_strobe_width: assert property (
        $fell(card_pins_out.iord_n) |-> (!card_pins_out.iord_n)[*7])
        else $error("read strobe shorter than least width");

    a_wr_strobe_width: assert property (
        $fell(card_pins_out.iowr_n) |-> (!card_pins_out.iowr_n && card_data_oe_out)[*7])
        else $error("write strobe short or data released");

    c_read_done: cover property (
        $fell(ide_waitrequest_out) && !st_q.is_write);
    c_write_done: cover property (
        $fell(ide_waitrequest_out) && st_q.is_write);
    c_detect_irq: cover property ($rose(detect_irq_out));
    c_card_irq: cover property ($rose(card_irq_out));
endmodule : sci_ide_port_ctl
`default_nettype wire

// >>> rtl/sci_pkg.sv
// Shared constants and types for the storage card task-file port controller
package sci_pkg;

    // Bus widths
    localparam int IDE_ADDR_W = 4;
    localparam int IDE_DATA_W = 16;
    localparam int CTL_ADDR_W = 2;
    localparam int CTL_DATA_W = 32;
    localparam int CARD_ADDR_W = 11;

    // Control port word indices
    localparam logic [1:0] CTL_CONTROL_IDX = 2'h0;
    localparam logic [1:0] CTL_IRQ_IDX = 2'h1;
    localparam logic [1:0] CTL_RSVD2_IDX = 2'h2;
    localparam logic [1:0] CTL_RSVD3_IDX = 2'h3;

    // Field positions in the card control word
    localparam int PRESENT_BIT = 0;
    localparam int POWER_BIT = 1;
    localparam int RESET_BIT = 2;
    localparam int DET_IRQ_BIT = 3;
    // Field position in the interrupt control word
    localparam int CARD_IRQ_BIT = 0;

    // Task-file offset bit that selects the second chip select
    localparam int IDE_CS1_BIT = 3;

    // Chip select patterns (active low)
    localparam logic [1:0] CS_NONE = 2'h3;
    localparam logic [1:0] CS_BLOCK0 = 2'h2;
    localparam logic [1:0] CS_BLOCK1 = 2'h1;

    // Reset values of the software bits
    localparam logic POWER_RESET = 1'b0;
    localparam logic RESET_HOLD_RESET = 1'b0;
    localparam logic DET_IRQ_EN_RESET = 1'b0;
    localparam logic CARD_IRQ_EN_RESET = 1'b0;

    // Register cycle timing, times in ns
    localparam int CLK_PERIOD_NS = 25;
    localparam int SETUP_NS = 75;
    localparam int STROBE_NS = 175;
    localparam int HOLD_NS = 25;
    localparam int RECOVER_NS = 325;

    // Least times rounded up to whole cycles
    localparam int SETUP_CYC = (SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int STROBE_CYC = (STROBE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int HOLD_CYC = (HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int RECOVER_CYC = (RECOVER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // Phase timer loads (timer expires after load plus one cycles)
    localparam int TMR_W = 4;
    localparam logic [TMR_W-1:0] SETUP_LOAD = TMR_W'(SETUP_CYC - 1);
    localparam logic [TMR_W-1:0] STROBE_LOAD = TMR_W'(STROBE_CYC - 1);
    localparam logic [TMR_W-1:0] HOLD_LOAD = TMR_W'(HOLD_CYC - 1);
    localparam logic [TMR_W-1:0] RECOVER_LOAD = TMR_W'(RECOVER_CYC - 1);

    // Register cycle phases
    typedef enum logic [5:0] {
        PIO_IDLE = 6'h01,
        PIO_SETUP = 6'h02,
        PIO_STROBE = 6'h04,
        PIO_HOLD = 6'h08,
        PIO_DONE = 6'h10,
        PIO_RECOVER = 6'h20
    } sci_pio_state_type;

    // Card-side output pins
    typedef struct packed {
        logic [CARD_ADDR_W-1:0] addr;
        logic [1:0] cs_n;
        logic iord_n;
        logic iowr_n;
        logic we_n;
        logic atasel_n;
        logic rfu;
        logic power;
        logic reset_n;
    } sci_pin_type;

    localparam sci_pin_type PIN_RESET = '{
        addr: 11'h000, cs_n: 2'h3, iord_n: 1'b1, iowr_n: 1'b1, we_n: 1'b1,
        atasel_n: 1'b0, rfu: 1'b0, power: 1'b0, reset_n: 1'b1};

    // Whole state of the top module
    typedef struct packed {
        sci_pio_state_type state;
        sci_pin_type pins;
        logic [IDE_DATA_W-1:0] data_out;
        logic data_oe;
        logic is_write;
        logic waitreq;
        logic [IDE_DATA_W-1:0] ide_rdata;
        logic [CTL_DATA_W-1:0] ctl_rdata;
        logic present;
        logic power_on;
        logic reset_hold;
        logic det_irq_en;
        logic card_irq_en;
        logic det_pending;
        logic det_irq;
        logic card_irq;
    } sci_state_type;

    localparam sci_state_type STATE_RESET = '{
        state: PIO_IDLE, pins: PIN_RESET, data_out: 16'h0000, data_oe: 1'b0,
        is_write: 1'b0, waitreq: 1'b1, ide_rdata: 16'h0000, ctl_rdata: 32'h00000000,
        present: 1'b0, power_on: POWER_RESET, reset_hold: RESET_HOLD_RESET,
        det_irq_en: DET_IRQ_EN_RESET, card_irq_en: CARD_IRQ_EN_RESET,
        det_pending: 1'b0, det_irq: 1'b0, card_irq: 1'b0};

endpackage : sci_pkg

// >>> rtl/sci_sync2.sv
`timescale 1ns/1ps
`default_nettype none
// Two-stage synchroniser for pins from outside the clock domain
module sci_sync2 #(
    parameter int W = 1
) (
    // Clock and reset
    input wire logic clk_in,
    input wire logic resetn_in,
    // Asynchronous input and synchronised output
    input wire logic [W-1:0] async_in,
    output logic [W-1:0] sync_out
);
    // Both stages as one state word
    typedef struct packed {
        logic [W-1:0] meta;
        logic [W-1:0] stable;
    } sci_sync_type;

    sci_sync_type st_q; // Registered stages
    sci_sync_type st_d; // Next stages

    // First stage only feeds the second
    always_comb
    begin
        st_d.meta = async_in;
        st_d.stable = st_q.meta;
    end

    // Stage registers
    always_ff @(posedge clk_in or negedge resetn_in)
    begin
        if (!resetn_in)
            st_q <= '0;
        else
            st_q <= st_d;
    end

    assign sync_out = st_q.stable;
endmodule : sci_sync2
`default_nettype wire

// >>> rtl/sci_phase_timer.sv
`timescale 1ns/1ps
`default_nettype none
// Down counter that times one phase of a register cycle
module sci_phase_timer #(
    parameter int W = 4
) (
    // Clock and reset
    input wire logic clk_in,
    input wire logic resetn_in,
    // Load request and value
    input wire logic load_in,
    input wire logic [W-1:0] value_in,
    // High while the count stands at zero
    output logic expired_out
);
    // Counter state
    typedef struct packed {
        logic [W-1:0] count;
    } sci_timer_type;

    sci_timer_type st_q; // Registered count
    sci_timer_type st_d; // Next count

    // Load, else count down to zero and stay
    always_comb
    begin
        st_d = st_q;
        if (load_in)
            st_d.count = value_in;
        else if (st_q.count != '0)
            st_d.count = st_q.count - W'(1);
    end

    // Count register
    always_ff @(posedge clk_in or negedge resetn_in)
    begin
        if (!resetn_in)
            st_q <= '0;
        else
            st_q <= st_d;
    end

    assign expired_out = (st_q.count == '0);
endmodule : sci_phase_timer
`default_nettype wire

// >>> tb/sci_card_model.sv
`timescale 1ns/1ps
`default_nettype none
// Behavioural card in true IDE mode: task-file registers behind the strobes
module sci_card_model (
    // Pins from the controller
    input wire sci_pkg::sci_pin_type pins_in,
    input wire logic [sci_pkg::IDE_DATA_W-1:0] data_in,
    input wire logic data_oe_in,
    // Data the card drives back
    output logic [sci_pkg::IDE_DATA_W-1:0] data_out
);
    import sci_pkg::*;
    logic [IDE_DATA_W-1:0] regs_q [16]; // Register contents by offset
    logic [IDE_DATA_W-1:0] last_q = 16'h0000; // Last value driven on a read
    logic [3:0] idx; // Offset seen from chip select and address
    logic sel; // Some chip select active
    // Second chip select adds eight to the index
    assign idx = {pins_in.cs_n[0], pins_in.addr[2:0]};
    assign sel = (pins_in.cs_n != CS_NONE);
    // Written data latched as the write strobe ends
    always @(posedge pins_in.iowr_n)
    begin
        if (sel && data_oe_in)
            regs_q[idx] <= data_in;
    end
    // Remember the driven value so the released bus never repeats it
    always @(posedge pins_in.iord_n)
    begin
        if (sel)
            last_q <= regs_q[idx];
    end
    // Drive only during the read strobe
    assign data_out = (sel && !pins_in.iord_n) ? regs_q[idx] : ~last_q;
endmodule : sci_card_model
`default_nettype wire

// >>> tb/sci_ide_port_ctl_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
// Self-checking bench for the task-file port controller
module sci_ide_port_ctl_tb_top;
    import sci_pkg::*;
    `define CHK(got, exp) begin checked++; if ((got) !== (exp)) begin n_fail++; \
        $display("[FAIL] t=%0t got %h expected %h", $time, got, exp); end end
    logic clk_in = 1'b0;
    logic resetn_in = 1'b0;
    logic [IDE_ADDR_W-1:0] ide_address_in = '0;
    logic ide_read_in = 1'b0;
    logic ide_write_in = 1'b0;
    logic [IDE_DATA_W-1:0] ide_writedata_in = '0;
    logic [IDE_DATA_W-1:0] ide_readdata_out;
    logic ide_waitrequest_out;
    logic [CTL_ADDR_W-1:0] ctl_address_in = '0;
    logic ctl_read_in = 1'b0;
    logic ctl_write_in = 1'b0;
    logic [CTL_DATA_W-1:0] ctl_writedata_in = '0;
    logic [CTL_DATA_W-1:0] ctl_readdata_out;
    sci_pin_type card_pins_out;
    logic [IDE_DATA_W-1:0] card_data_out;
    logic card_data_oe_out;
    logic [IDE_DATA_W-1:0] card_data_in;
    logic card_detect_in = 1'b0;
    logic card_intrq_in = 1'b0;
    logic card_iordy_in = 1'b1;
    logic detect_irq_out;
    logic card_irq_out;
    int n_fail = 0;
    int checked = 0;
    logic [31:0] d; // Control read result
    logic [15:0] rd; // Task-file read result
    int n; // Cycles to completion
    // Setup, strobe and hold after the accept edge; waitrequest low in the cycle after
    localparam int XFER_CYC = SETUP_CYC + STROBE_CYC + HOLD_CYC + 1;
    localparam logic [3:0] OFFS [9] = '{0, 1, 2, 3, 4, 5, 6, 7, 14};

    // 40 MHz clock
    always #12.5 clk_in = ~clk_in;

    sci_ide_port_ctl dut (
        .clk_in(clk_in), .resetn_in(resetn_in),
        .ide_address_in(ide_address_in), .ide_read_in(ide_read_in),
        .ide_write_in(ide_write_in), .ide_writedata_in(ide_writedata_in),
        .ide_readdata_out(ide_readdata_out), .ide_waitrequest_out(ide_waitrequest_out),
        .ctl_address_in(ctl_address_in), .ctl_read_in(ctl_read_in),
        .ctl_write_in(ctl_write_in), .ctl_writedata_in(ctl_writedata_in),
        .ctl_readdata_out(ctl_readdata_out), .card_pins_out(card_pins_out),
        .card_data_out(card_data_out), .card_data_oe_out(card_data_oe_out),
        .card_data_in(card_data_in), .card_detect_in(card_detect_in),
        .card_intrq_in(card_intrq_in), .card_iordy_in(card_iordy_in),
        .detect_irq_out(detect_irq_out), .card_irq_out(card_irq_out)
    );

    sci_card_model card (
        .pins_in(card_pins_out), .data_in(card_data_out),
        .data_oe_in(card_data_oe_out), .data_out(card_data_in)
    );

    // Task-file transfer held until waitrequest is sampled low
    task automatic ide_xfer(input logic wr, input logic [3:0] a, input logic [15:0] wd,
                            output logic [15:0] r, output int c);
        c = 0;
        @(negedge clk_in);
        ide_address_in = a;
        ide_writedata_in = wd;
        ide_write_in = wr;
        ide_read_in = !wr;
        // Looked at mid-cycle, where waitrequest has settled
        do
        begin
            @(negedge clk_in);
            c++;
        end while (ide_waitrequest_out !== 1'b0 && c < 400);
        r = ide_readdata_out;
        @(negedge clk_in);
        ide_read_in = 1'b0;
        ide_write_in = 1'b0;
        // Let recovery pass so the next request is taken at once
        repeat (RECOVER_CYC - 1) @(negedge clk_in);
    endtask : ide_xfer

    // One-cycle control write
    task automatic ctl_wr(input logic [1:0] a, input logic [31:0] v);
        @(negedge clk_in);
        ctl_address_in = a;
        ctl_writedata_in = v;
        ctl_write_in = 1'b1;
        @(negedge clk_in);
        ctl_write_in = 1'b0;
    endtask : ctl_wr

    // Control read, data one cycle after the request
    task automatic ctl_rd(input logic [1:0] a, output logic [31:0] v);
        @(negedge clk_in);
        ctl_address_in = a;
        ctl_read_in = 1'b1;
        @(negedge clk_in);
        ctl_read_in = 1'b0;
        v = ctl_readdata_out;
    endtask : ctl_rd

    // Counts and verdict
    task automatic test_done();
        $display("checked %0d, failed %0d", checked, n_fail);
        if (n_fail == 0 && checked > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : test_done

    // Watchdog, several times the expected run
    initial
    begin
        #100us;
        n_fail++;
        $display("[FAIL] t=%0t watchdog expired", $time);
        test_done();
    end

    // Main sequence
    initial
    begin
        repeat (2) @(posedge clk_in);
        @(negedge clk_in);
        resetn_in = 1'b1;
        repeat (4) @(negedge clk_in);
        ctl_rd(CTL_CONTROL_IDX, d);
        `CHK(d, 32'h00000000)
        ctl_rd(CTL_IRQ_IDX, d);
        `CHK(d, 32'h00000000)
        `CHK(card_pins_out.power, 1'b0)
        `CHK(card_pins_out.reset_n, 1'b1)
        `CHK({card_pins_out.we_n, card_pins_out.atasel_n, card_pins_out.rfu}, 3'b100)
        `CHK(card_pins_out.cs_n, CS_NONE)
        $display("test reset values done");
        // Control bits, reserved bits and words
        ctl_wr(CTL_CONTROL_IDX, 32'hFFFFFFFF);
        `CHK(card_pins_out.power, 1'b1)
        `CHK(card_pins_out.reset_n, 1'b0)
        ctl_rd(CTL_CONTROL_IDX, d);
        `CHK(d, 32'h0000000E)
        ctl_wr(CTL_CONTROL_IDX, 32'h00000002);
        `CHK(card_pins_out.reset_n, 1'b1)
        ctl_wr(CTL_IRQ_IDX, 32'hFFFFFFFF);
        ctl_rd(CTL_IRQ_IDX, d);
        `CHK(d, 32'h00000001)
        for (int w = 2; w < 4; w++)
        begin
            ctl_wr(w[1:0], 32'hFFFFFFFF);
            ctl_rd(w[1:0], d);
            `CHK(d, 32'h00000000)
        end
        $display("test control port done");
        // Offsets 0-7 and 14 written, then all read back
        foreach (OFFS[i])
        begin
            ide_xfer(1'b1, OFFS[i], 16'hC300 + 16'(OFFS[i]), rd, n);
            `CHK(n, XFER_CYC)
        end
        foreach (OFFS[i])
        begin
            ide_xfer(1'b0, OFFS[i], 16'h0000, rd, n);
            `CHK(rd, 16'hC300 + 16'(OFFS[i]))
            `CHK(n, XFER_CYC)
        end
        // Card not ready stretches the strobe
        card_iordy_in = 1'b0;
        fork
            begin
                repeat (20) @(negedge clk_in);
                card_iordy_in = 1'b1;
            end
        join_none
        ide_xfer(1'b0, 4'h3, 16'h0000, rd, n);
        `CHK(rd, 16'hC303)
        `CHK(n > XFER_CYC, 1'b1)
        $display("test task-file port done");
        // Insertion and removal interrupts, cleared by reading
        ctl_wr(CTL_CONTROL_IDX, 32'h00000008);
        card_detect_in = 1'b1;
        repeat (6) @(negedge clk_in);
        `CHK(detect_irq_out, 1'b1)
        `CHK(card_irq_out, 1'b0)
        ctl_rd(CTL_CONTROL_IDX, d);
        `CHK(d, 32'h00000009)
        repeat (2) @(negedge clk_in);
        `CHK(detect_irq_out, 1'b0)
        card_detect_in = 1'b0;
        repeat (6) @(negedge clk_in);
        `CHK(detect_irq_out, 1'b1)
        ctl_rd(CTL_CONTROL_IDX, d);
        `CHK(d, 32'h00000008)
        repeat (2) @(negedge clk_in);
        `CHK(detect_irq_out, 1'b0)
        ctl_wr(CTL_CONTROL_IDX, 32'h00000000);
        card_detect_in = 1'b1;
        repeat (6) @(negedge clk_in);
        `CHK(detect_irq_out, 1'b0)
        $display("test detect interrupt done");
        // Relayed card interrupt gated by its enable
        ctl_wr(CTL_IRQ_IDX, 32'h00000000);
        card_intrq_in = 1'b1;
        repeat (6) @(negedge clk_in);
        `CHK(card_irq_out, 1'b0)
        ctl_wr(CTL_IRQ_IDX, 32'h00000001);
        repeat (4) @(negedge clk_in);
        `CHK(card_irq_out, 1'b1)
        `CHK(detect_irq_out, 1'b0)
        card_intrq_in = 1'b0;
        repeat (5) @(negedge clk_in);
        `CHK(card_irq_out, 1'b0)
        $display("test card interrupt done");
        test_done();
    end
endmodule : sci_ide_port_ctl_tb_top
`default_nettype wire
